// file: logic/sfd_forward.sv
// forwarding decision: tail tags, igmp trap, mirroring, vlan and mac tables
// Summary of operation
// - host tail tag bits 3..1 pick port 1, 2, 3 or all; 000 reserved
// - host tail tag bits 5..4 values 0..3 select destination transmit queue
// - tail tag bit 6 forces delivery to named ports despite vlan drop rules; rx errors still kill
// - tail tag bit 7 ignores the other bits and uses normal lookup
// - frames to host carry ingress port code 01, 10, 11 in bits 1..0
// - with snooping on, igmp frames from front ports have their lookup result replaced by the host port
// - igmp means ipv4 ethernet or snap frame with protocol 0x2
// - igmp snooping active only while global control 5 bit 6 set
// - tail tags added and read only while register 12 bit 1 set
// - frames received on rx mirror source also copied to sniffer port
// - option lets errored frames reach their destination under rx mirroring
// - frames sent to a tx mirror source also copied to sniffer port
// - register 5 bit 0 mirrors only frames both rx and tx sniffed
// - register 17 sets any rx or tx sources and any sniffer ports
// - 128 entry vlan table maps vids to 7 bit filter groups
// - untagged or null vid frames use port default vid in vlan mode
// - unknown vid in vlan mode drops the frame and skips learning
// - no static result: dynamic port on hit, else flood vlan members
// - static hit used when group flag clear or group matches
// - unknown source plus group learned; known pair gets timestamp refresh
// - per port ingress filtering and non default vid discard
// - tail tags exist only on the host port; bit 0 unused
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module sfd_forward (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sfd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sfd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frm_valid,
  input wire logic [1:0] frm_port,
  input wire logic [47:0] frm_da,
  input wire logic [47:0] frm_sa,
  input wire logic frm_tagged,
  input wire logic [11:0] frm_vid,
  input wire logic [1:0] frm_prio,
  input wire logic frm_ip_ether,
  input wire logic frm_ip_snap,
  input wire logic [3:0] frm_ip_ver,
  input wire logic [7:0] frm_ip_proto,
  input wire logic frm_rx_err,
  input wire logic [7:0] frm_tail,
  output logic dec_valid,
  output logic [3:0] dec_ports,
  output logic [1:0] dec_queue,
  output logic dec_add_tag,
  output logic [7:0] dec_tag,
  output logic dec_strip,
  output logic dec_fcs
);
  localparam int NP = sfd_pkg::NPORT;

  function automatic logic [3:0] port_mask(input logic [1:0] p);
    port_mask = 4'h1 << p;
  endfunction

  function automatic logic [3:0] tt_dest(input logic [2:0] b);
    unique case (b)
      3'h1: tt_dest = 4'h1;
      3'h2: tt_dest = 4'h2;
      3'h4: tt_dest = 4'h4;
      3'h7: tt_dest = 4'h7;
      default: tt_dest = 4'h0;
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [7:0] i);
    reg_mapped = (i == sfd_pkg::GCTRL_IDX) || (i == sfd_pkg::TAIL_IDX) ||
                 (i == sfd_pkg::MIRROR_IDX) || (i == sfd_pkg::PCTRL2_IDX) ||
                 (i >= sfd_pkg::PORT_DEFAULT_VLAN_ID_IDX && i < sfd_pkg::PORT_DEFAULT_VLAN_ID_IDX + 8'h04) ||
                 (i >= sfd_pkg::VLAN_IDX && i <= sfd_pkg::STATUS_IDX);
  endfunction

  function automatic logic [31:0] strb(input logic [31:0] o,
                                      input logic [31:0] n,
                                      input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      o[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
    strb = o;
  endfunction

  // configuration
  logic [7:0] gctrl_q;
  logic [7:0] tail_q;
  logic [31:0] mirror_q;
  logic [31:0] pctrl2_q;
  logic [11:0] port_default_vlan_id_q [NP];
  logic [2:0] stsel_q;
  logic [31:0] stlo_q;
  logic [15:0] learn_cnt_q;
  logic [15:0] drop_cnt_q;
  // tables
  logic [11:0] vl_vid_q [sfd_pkg::VLAN_ENTRIES];
  logic [6:0] vl_fid_q [sfd_pkg::VLAN_ENTRIES];
  logic [4:0] vl_mem_q [sfd_pkg::VLAN_ENTRIES];
  logic [sfd_pkg::VLAN_ENTRIES-1:0] vl_ok_q;
  logic [47:0] st_da_q [sfd_pkg::STAT_ENTRIES];
  logic [4:0] st_ports_q [sfd_pkg::STAT_ENTRIES];
  logic [6:0] st_fid_q [sfd_pkg::STAT_ENTRIES];
  logic [sfd_pkg::STAT_ENTRIES-1:0] st_use_q;
  logic [sfd_pkg::STAT_ENTRIES-1:0] st_ok_q;
  logic [47:0] dy_mac_q [sfd_pkg::DYN_ENTRIES];
  logic [6:0] dy_fid_q [sfd_pkg::DYN_ENTRIES];
  logic [2:0] dy_port_q [sfd_pkg::DYN_ENTRIES];
  logic [7:0] dy_ts_q [sfd_pkg::DYN_ENTRIES];
  logic [sfd_pkg::DYN_ENTRIES-1:0] dy_ok_q;
  logic [3:0] dy_ptr_q;
  logic [7:0] ts_q;
  // bus
  logic wr_take_q;
  logic ar_take_q;
  logic [7:0] widx;
  logic [7:0] ridx;
  logic wr_fire;

  assign widx = s_axi_awaddr[9:2];
  assign ridx = s_axi_araddr[9:2];
  assign wr_fire = wr_take_q;

  wire vlan_en = gctrl_q[sfd_pkg::GC_VLAN_BIT];
  wire igmp_en = gctrl_q[sfd_pkg::GC_IGMP_BIT];
  wire and_mode = gctrl_q[sfd_pkg::GC_AND_BIT];
  wire tail_en = tail_q[sfd_pkg::TAIL_EN_BIT];

  // decision datapath
  logic [11:0] vid_eff;
  logic [6:0] vidx;
  logic vl_hit;
  logic [6:0] filter_group_id;
  logic [3:0] members;
  logic st_hit;
  logic [2:0] st_sel;
  logic dy_hit;
  logic [3:0] dy_sel;
  logic sa_hit;
  logic [3:0] sa_sel;
  logic from_host;
  logic tt_direct;
  logic tt_force;
  logic [3:0] lookup;
  logic [3:0] base;
  logic [3:0] fwd;
  logic [3:0] rx_src;
  logic [3:0] tx_src;
  logic [3:0] snif;
  logic drop_vlan;
  logic is_igmp;
  logic rxm;
  logic txm;
  logic mir;
  logic err_kill;
  logic learn;
  logic [3:0] ports_d;

  always_comb begin
    from_host = (frm_port == sfd_pkg::HOST_PORT) && tail_en;
    tt_direct = from_host && !frm_tail[7];
    tt_force = tt_direct && frm_tail[6];
    vid_eff = (!frm_tagged || frm_vid == 12'h000) ?
              port_default_vlan_id_q[frm_port] : frm_vid;
    // vlan slot is the low vid bits; stored vid must match in full
    vidx = vid_eff[6:0];
    vl_hit = vl_ok_q[vidx] && (vl_vid_q[vidx] == vid_eff);
    filter_group_id = vlan_en ? vl_fid_q[vidx] : 7'h00;
    members = vlan_en ? vl_mem_q[vidx][3:0] : 4'hF;
    st_hit = 1'b0;
    st_sel = 3'h0;
    for (int i = 0; i < sfd_pkg::STAT_ENTRIES; i++) begin
      if (st_ok_q[i] && st_da_q[i] == frm_da) begin
        st_hit = 1'b1;
        st_sel = 3'(i);
      end
    end
    dy_hit = 1'b0;
    dy_sel = 4'h0;
    sa_hit = 1'b0;
    sa_sel = 4'h0;
    for (int i = 0; i < sfd_pkg::DYN_ENTRIES; i++) begin
      if (dy_ok_q[i] && dy_fid_q[i] == filter_group_id && dy_mac_q[i] == frm_da) begin
        dy_hit = 1'b1;
        dy_sel = 4'(i);
      end
      if (dy_ok_q[i] && dy_fid_q[i] == filter_group_id && dy_mac_q[i] == frm_sa) begin
        sa_hit = 1'b1;
        sa_sel = 4'(i);
      end
    end
    if (st_hit && (!st_use_q[st_sel] || st_fid_q[st_sel] == filter_group_id)) begin
      lookup = st_ports_q[st_sel][3:0];
    end else if (dy_hit) begin
      lookup = port_mask(dy_port_q[dy_sel][1:0]);
    end else begin
      lookup = members;
    end
    base = tt_direct ? tt_dest(frm_tail[3:1]) : lookup;
    is_igmp = (frm_ip_ether || frm_ip_snap) && frm_ip_ver == sfd_pkg::IP_VER4
              && frm_ip_proto == sfd_pkg::IP_PROTO_IGMP;
    if (igmp_en && is_igmp && frm_port != sfd_pkg::HOST_PORT) begin
      base = port_mask(sfd_pkg::HOST_PORT);
    end
    base = base & ~port_mask(frm_port);
    drop_vlan = vlan_en && (!vl_hit ||
      (pctrl2_q[8*frm_port + sfd_pkg::PC2_FILT_OFF] && !members[frm_port]) ||
      (pctrl2_q[8*frm_port + sfd_pkg::PC2_NPVID_OFF] &&
       vid_eff != port_default_vlan_id_q[frm_port]));
    fwd = (drop_vlan && !tt_force) ? 4'h0 : base;
    for (int p = 0; p < NP; p++) begin
      rx_src[p] = mirror_q[4*p + sfd_pkg::MIR_RX_OFF];
      tx_src[p] = mirror_q[4*p + sfd_pkg::MIR_TX_OFF];
      snif[p] = mirror_q[4*p + sfd_pkg::MIR_SNIF_OFF];
    end
    rxm = rx_src[frm_port];
    txm = |(fwd & tx_src);
    mir = and_mode ? (rxm && txm) : (rxm || txm);
    // bad frames are killed unless rx mirrored with forwarding of bad on
    err_kill = frm_rx_err && !(rxm && mirror_q[sfd_pkg::MIR_FWD_BAD_BIT]);
    ports_d = (err_kill ? 4'h0 : fwd) |
              ((mir && (!frm_rx_err || rxm)) ? snif : 4'h0);
    learn = !(vlan_en && !vl_hit) && !frm_rx_err;
  end

  // decision outputs, one cycle after the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_valid <= 1'b0;
      dec_ports <= 4'h0;
      dec_queue <= 2'h0;
      dec_add_tag <= 1'b0;
      dec_tag <= 8'h00;
      dec_strip <= 1'b0;
      dec_fcs <= 1'b0;
    end else begin
      dec_valid <= frm_valid;
      if (frm_valid) begin
        dec_ports <= ports_d;
        dec_queue <= tt_direct ? frm_tail[5:4] : frm_prio;
        dec_add_tag <= tail_en && ports_d[sfd_pkg::HOST_PORT] &&
                       frm_port != sfd_pkg::HOST_PORT;
        dec_tag <= {6'h00, frm_port + 2'h1};
        dec_strip <= from_host;
        dec_fcs <= from_host || (tail_en && ports_d[sfd_pkg::HOST_PORT] &&
                   frm_port != sfd_pkg::HOST_PORT);
      end
    end
  end

  // source learning; round robin replacement keeps the table small
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dy_ok_q <= '0;
      dy_ptr_q <= 4'h0;
      ts_q <= 8'h00;
      learn_cnt_q <= 16'h0000;
      drop_cnt_q <= 16'h0000;
    end else begin
      ts_q <= ts_q + 8'h01;
      if (frm_valid && ports_d == 4'h0) begin
        drop_cnt_q <= drop_cnt_q + 16'h0001;
      end
      if (frm_valid && learn) begin
        if (sa_hit) begin
          dy_ts_q[sa_sel] <= ts_q;
        end else begin
          dy_mac_q[dy_ptr_q] <= frm_sa;
          dy_fid_q[dy_ptr_q] <= filter_group_id;
          dy_port_q[dy_ptr_q] <= {1'b0, frm_port};
          dy_ts_q[dy_ptr_q] <= ts_q;
          dy_ok_q[dy_ptr_q] <= 1'b1;
          dy_ptr_q <= dy_ptr_q + 4'h1;
          learn_cnt_q <= learn_cnt_q + 16'h0001;
        end
      end
    end
  end

  // register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gctrl_q <= sfd_pkg::GCTRL_RST;
      tail_q <= sfd_pkg::GCTRL_RST;
      mirror_q <= sfd_pkg::WORD_RST;
      pctrl2_q <= sfd_pkg::WORD_RST;
      stsel_q <= 3'h0;
      stlo_q <= sfd_pkg::WORD_RST;
      vl_ok_q <= '0;
      st_ok_q <= '0;
      st_use_q <= '0;
      for (int p = 0; p < NP; p++) begin
        port_default_vlan_id_q[p] <= sfd_pkg::PORT_DEFAULT_VLAN_ID_RST;
      end
    end else if (wr_fire) begin
      if (widx == sfd_pkg::GCTRL_IDX && s_axi_wstrb[0]) begin
        gctrl_q <= s_axi_wdata[7:0];
      end
      if (widx == sfd_pkg::TAIL_IDX && s_axi_wstrb[0]) begin
        tail_q <= s_axi_wdata[7:0];
      end
      if (widx == sfd_pkg::MIRROR_IDX) begin
        mirror_q <= strb(mirror_q, s_axi_wdata, s_axi_wstrb);
      end
      if (widx == sfd_pkg::PCTRL2_IDX) begin
        pctrl2_q <= strb(pctrl2_q, s_axi_wdata, s_axi_wstrb);
      end
      for (int p = 0; p < NP; p++) begin
        if (widx == sfd_pkg::PORT_DEFAULT_VLAN_ID_IDX + 8'(p)) begin
          port_default_vlan_id_q[p] <= s_axi_wdata[11:0];
        end
      end
      if (widx == sfd_pkg::VLAN_IDX) begin
        vl_vid_q[s_axi_wdata[6:0]] <= s_axi_wdata[11:0];
        vl_mem_q[s_axi_wdata[6:0]] <= s_axi_wdata[16:12];
        vl_fid_q[s_axi_wdata[6:0]] <= s_axi_wdata[23:17];
        vl_ok_q[s_axi_wdata[6:0]] <= s_axi_wdata[sfd_pkg::VL_VALID_BIT];
      end
      if (widx == sfd_pkg::STSEL_IDX) begin
        stsel_q <= s_axi_wdata[2:0];
      end
      if (widx == sfd_pkg::STLO_IDX) begin
        stlo_q <= s_axi_wdata;
      end
      if (widx == sfd_pkg::STHI_IDX) begin
        st_da_q[stsel_q] <= {s_axi_wdata[15:0], stlo_q};
        st_ports_q[stsel_q] <= s_axi_wdata[20:16];
        st_use_q[stsel_q] <= s_axi_wdata[sfd_pkg::ST_USE_BIT];
        st_ok_q[stsel_q] <= s_axi_wdata[sfd_pkg::ST_VALID_BIT];
        st_fid_q[stsel_q] <= s_axi_wdata[29:23];
      end
    end
  end

  // write channel: address and data taken together in one handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_take_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sfd_pkg::RESP_OKAY;
    end else begin
      wr_take_q <= s_axi_awvalid && s_axi_wvalid && !wr_take_q &&
                   !s_axi_bvalid;
      if (wr_take_q) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_mapped(widx) ? sfd_pkg::RESP_OKAY :
                       sfd_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = wr_take_q;
  assign s_axi_wready = wr_take_q;

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_take_q <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= sfd_pkg::WORD_RST;
      s_axi_rresp <= sfd_pkg::RESP_OKAY;
    end else begin
      ar_take_q <= s_axi_arvalid && !ar_take_q && !s_axi_rvalid;
      if (ar_take_q) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= reg_mapped(ridx) ? sfd_pkg::RESP_OKAY :
                       sfd_pkg::RESP_SLVERR;
        unique case (ridx)
          sfd_pkg::GCTRL_IDX: s_axi_rdata <= {24'h000000, gctrl_q};
          sfd_pkg::TAIL_IDX: s_axi_rdata <= {24'h000000, tail_q};
          sfd_pkg::MIRROR_IDX: s_axi_rdata <= mirror_q;
          sfd_pkg::PCTRL2_IDX: s_axi_rdata <= pctrl2_q;
          sfd_pkg::STSEL_IDX: s_axi_rdata <= {29'h0, stsel_q};
          sfd_pkg::STLO_IDX: s_axi_rdata <= stlo_q;
          sfd_pkg::STATUS_IDX: s_axi_rdata <= {drop_cnt_q, learn_cnt_q};
          default: s_axi_rdata <= (ridx >= sfd_pkg::PORT_DEFAULT_VLAN_ID_IDX &&
                     ridx < sfd_pkg::PORT_DEFAULT_VLAN_ID_IDX + 8'h04) ?
                     {20'h00000, port_default_vlan_id_q[ridx[1:0]]} : 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_arready = ar_take_q;

  tt_queue_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frm_valid && tt_direct |=> dec_queue == $past(frm_tail[5:4]))
    else $error("queue not taken from tail tag");
  tt_dest_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frm_valid && tt_force && !frm_rx_err |=>
    (dec_ports & $past(base)) == $past(base))
    else $error("forced tail tag destination missing");
  tt_src_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dec_valid && dec_add_tag |-> dec_tag[1:0] != 2'h0 && dec_tag[7:2] == 6'h0)
    else $error("bad source code in tail tag");
  tt_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frm_valid && !tail_en |=> !dec_add_tag && !dec_strip)
    else $error("tail tag used while disabled");
  fcs_redo_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dec_valid |-> dec_fcs == (dec_add_tag || dec_strip))
    else $error("fcs recompute flag wrong");
  vid_nolearn_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frm_valid && vlan_en && !vl_hit |=> $stable(learn_cnt_q))
    else $error("learned on unknown vid");
  igmp_trap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frm_valid && igmp_en && is_igmp && frm_port != sfd_pkg::HOST_PORT |=>
    (dec_ports & ~$past(snif) & 4'h7) == 4'h0)
    else $error("igmp frame reached a front port");
  and_mirror_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frm_valid && and_mode && !(rxm && txm) |=>
    (dec_ports & ~$past(fwd)) == 4'h0)
    else $error("and mirror copied a frame");
  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule

// file: logic/sfd_pkg.sv
// constants for the switch forwarding decision block
package sfd_pkg;
  localparam int NPORT = 4;
  localparam logic [1:0] HOST_PORT = 2'h3;
  localparam int VLAN_ENTRIES = 128;
  localparam int STAT_ENTRIES = 8;
  localparam int DYN_ENTRIES = 16;
  localparam int ADDR_W = 10;
  // register indices; byte address is four times the index
  localparam logic [7:0] GCTRL_IDX = 8'h05;
  localparam logic [7:0] TAIL_IDX = 8'h0C;
  localparam logic [7:0] MIRROR_IDX = 8'h11;
  localparam logic [7:0] PCTRL2_IDX = 8'h20;
  localparam logic [7:0] PORT_DEFAULT_VLAN_ID_IDX = 8'h24;
  localparam logic [7:0] VLAN_IDX = 8'h30;
  localparam logic [7:0] STSEL_IDX = 8'h31;
  localparam logic [7:0] STLO_IDX = 8'h32;
  localparam logic [7:0] STHI_IDX = 8'h33;
  localparam logic [7:0] STATUS_IDX = 8'h34;
  // field positions
  localparam int GC_AND_BIT = 0;
  localparam int GC_IGMP_BIT = 6;
  localparam int GC_VLAN_BIT = 7;
  localparam int TAIL_EN_BIT = 1;
  localparam int MIR_RX_OFF = 0;
  localparam int MIR_TX_OFF = 1;
  localparam int MIR_SNIF_OFF = 2;
  localparam int MIR_FWD_BAD_BIT = 16;
  localparam int PC2_FILT_OFF = 6;
  localparam int PC2_NPVID_OFF = 5;
  localparam int VL_MEM_LSB = 12;
  localparam int VL_FID_LSB = 17;
  localparam int VL_VALID_BIT = 24;
  localparam int ST_PORTS_LSB = 16;
  localparam int ST_USE_BIT = 21;
  localparam int ST_VALID_BIT = 22;
  localparam int ST_FID_LSB = 23;
  // reset values and codes
  localparam logic [7:0] GCTRL_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [11:0] PORT_DEFAULT_VLAN_ID_RST = 12'h001;
  localparam logic [3:0] IP_VER4 = 4'h4;
  localparam logic [7:0] IP_PROTO_IGMP = 8'h02;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: test/sfd_host_model.sv
// host processor mac model: answers a frame back to the port it came from
`timescale 1ns/1ps
module sfd_host_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dec_valid,
  input wire logic [3:0] dec_ports,
  input wire logic dec_add_tag,
  input wire logic [7:0] dec_tag,
  input wire logic reply,
  output logic h_valid,
  output logic [7:0] h_tail
);
  logic [1:0] src_q;
  // only frames that really reach the host carry a source field
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= 2'h0;
    end else if (dec_valid && dec_ports[3] && dec_add_tag) begin
      src_q <= dec_tag[1:0];
    end
  end
  // source 01/10/11 becomes destination 001/010/100, bit 0 left clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_valid <= 1'b0;
      h_tail <= 8'h00;
    end else begin
      h_valid <= reply;
      if (reply) begin
        h_tail <= {4'h0, (src_q == 2'h3) ? 3'h4 : {1'b0, src_q}, 1'b0};
      end
    end
  end
endmodule

// file: test/tb_sfd_forward.sv
// testbench: register setup over axi4-lite and frame decision checks
`timescale 1ns/1ps
module tb_sfd_forward;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [sfd_pkg::ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d, st0;
  logic awready, wready, bvalid, arready, rvalid, h_v;
  logic [1:0] bresp, rresp, queue;
  logic b_v = 1'b0, rq = 1'b0, tagd = 1'b0, ipe = 1'b0, ips = 1'b0;
  logic err = 1'b0;
  logic [1:0] b_port = 2'h0;
  logic [47:0] da = 48'h0, sa = 48'h0000_0C00_0009;
  logic [11:0] vid = 12'h0;
  logic [3:0] ver = 4'h0, ports;
  logic [7:0] proto = 8'h00, b_tail = 8'h00, h_tail, tag;
  logic dv, atag, strip, fcs;
  int n_fail = 0, checks = 0, cyc = 0;
  localparam logic [47:0] XDA = 48'h0000_0A00_0001, HDA = 48'h0000_0A00_0002;
  localparam logic [47:0] YDA = 48'h0000_0A00_0003, ZDA = 48'h0000_0A00_0004;
  localparam logic [47:0] UDA = 48'h0000_0A00_000F, ADA = 48'h0000_0B00_0001;
  localparam logic [47:0] BDA = 48'h0000_0B00_0002, CDA = 48'h0000_0B00_0003;
  localparam logic [7:0] TL [6] = '{8'h02, 8'h14, 8'h28, 8'h3E, 8'h40, 8'h52};
  localparam logic [3:0] EP [6] = '{4'h1, 4'h2, 4'h4, 4'h7, 4'h0, 4'h1};
  localparam logic [1:0] EQ [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};

  sfd_forward dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frm_valid(b_v | h_v),
    .frm_port(h_v ? 2'h3 : b_port), .frm_da(da), .frm_sa(sa),
    .frm_tagged(tagd), .frm_vid(vid), .frm_prio(2'h0), .frm_ip_ether(ipe),
    .frm_ip_snap(ips), .frm_ip_ver(ver), .frm_ip_proto(proto),
    .frm_rx_err(err), .frm_tail(h_v ? h_tail : b_tail), .dec_valid(dv),
    .dec_ports(ports), .dec_queue(queue), .dec_add_tag(atag),
    .dec_tag(tag), .dec_strip(strip), .dec_fcs(fcs));

  sfd_host_model host_u (.aclk(aclk), .aresetn(aresetn), .dec_valid(dv),
    .dec_ports(ports), .dec_add_tag(atag), .dec_tag(tag), .reply(rq),
    .h_valid(h_v), .h_tail(h_tail));

  initial begin
    forever #5 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // a hung handshake ends the run here instead of stalling forever
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [31:0] v,
                    input logic [1:0] er = sfd_pkg::RESP_OKAY);
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    cmp(bresp, er);
  endtask

  task automatic rd(input logic [7:0] i, input logic [1:0] er,
                    output logic [31:0] v);
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    v = rdata;
    cmp(rresp, er);
  endtask

  // static entry: select slot, low address word, then the committing word
  task automatic st(input logic [2:0] s, input logic [47:0] a,
                    input logic [4:0] p, input logic u, input logic [6:0] f);
    wr(sfd_pkg::STSEL_IDX, {29'h0, s});
    wr(sfd_pkg::STLO_IDX, a[31:0]);
    wr(sfd_pkg::STHI_IDX, {2'h0, f, 1'b1, u, p, a[47:32]});
  endtask

  task automatic vl(input logic [11:0] v, input logic [4:0] m);
    wr(sfd_pkg::VLAN_IDX, {7'h0, 1'b1, 7'h03, m, v});
  endtask

  task automatic post(input logic [3:0] e);
    b_v <= 1'b0;
    rq <= 1'b0;
    #1;
    cmp(dv, 1'b1);
    cmp(ports, e);
  endtask

  task automatic fr(input logic [1:0] p, input logic [47:0] a,
                    input logic t, input logic [11:0] v,
                    input logic [7:0] tl, input logic [3:0] e);
    @(posedge aclk);
    b_v <= 1'b1;
    b_port <= p;
    da <= a;
    tagd <= t;
    vid <= v;
    b_tail <= tl;
    @(posedge aclk);
    post(e);
  endtask

  task automatic reply(input logic [3:0] e);
    @(posedge aclk);
    rq <= 1'b1;
    @(posedge aclk);
    rq <= 1'b0;
    @(posedge aclk);
    post(e);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    cmp(dv, 1'b0);
    cmp(ports, 4'h0);
    rd(sfd_pkg::PORT_DEFAULT_VLAN_ID_IDX, sfd_pkg::RESP_OKAY, d);
    cmp(d, {20'h0, sfd_pkg::PORT_DEFAULT_VLAN_ID_RST});
    rd(8'h3F, sfd_pkg::RESP_SLVERR, d);
    cmp(d, sfd_pkg::WORD_RST);
    wr(8'h3F, 32'hFFFF_FFFF, sfd_pkg::RESP_SLVERR);
    $display("test reset done");
    st(3'h0, XDA, 5'h02, 1'b0, 7'h00);
    st(3'h1, HDA, 5'h08, 1'b0, 7'h00);
    st(3'h2, YDA, 5'h01, 1'b1, 7'h04);
    st(3'h3, ZDA, 5'h04, 1'b1, 7'h03);
    fr(2'h3, XDA, 1'b0, 12'h0, 8'h44, 4'h2);
    cmp(strip, 1'b0);
    fr(2'h0, HDA, 1'b0, 12'h0, 8'h00, 4'h8);
    cmp(atag, 1'b0);
    wr(sfd_pkg::TAIL_IDX, 32'h0000_0002);
    for (int k = 0; k < 6; k++) begin
      fr(2'h3, XDA, 1'b0, 12'h0, TL[k], EP[k]);
      cmp(queue, EQ[k]);
      cmp(strip, 1'b1);
      cmp(fcs, 1'b1);
    end
    fr(2'h3, XDA, 1'b0, 12'h0, 8'hC4, 4'h2);
    for (int p = 0; p < 3; p++) begin
      fr(p[1:0], HDA, 1'b0, 12'h0, 8'h00, 4'h8);
      cmp(atag, 1'b1);
      cmp(tag, p + 1);
      cmp(fcs, 1'b1);
      reply(4'h1 << p);
    end
    $display("test tail tag done");
    ipe <= 1'b1;
    ver <= sfd_pkg::IP_VER4;
    proto <= sfd_pkg::IP_PROTO_IGMP;
    fr(2'h0, XDA, 1'b0, 12'h0, 8'h00, 4'h2);
    wr(sfd_pkg::GCTRL_IDX, 32'h0000_0040);
    fr(2'h0, XDA, 1'b0, 12'h0, 8'h00, 4'h8);
    ipe <= 1'b0;
    ips <= 1'b1;
    fr(2'h0, XDA, 1'b0, 12'h0, 8'h00, 4'h8);
    proto <= 8'h03;
    fr(2'h0, XDA, 1'b0, 12'h0, 8'h00, 4'h2);
    proto <= sfd_pkg::IP_PROTO_IGMP;
    ver <= 4'h6;
    fr(2'h0, XDA, 1'b0, 12'h0, 8'h00, 4'h2);
    ips <= 1'b0;
    $display("test igmp done");
    wr(sfd_pkg::GCTRL_IDX, 32'h0000_0000);
    wr(sfd_pkg::MIRROR_IDX, 32'h0000_0401);
    fr(2'h0, XDA, 1'b0, 12'h0, 8'h00, 4'h6);
    fr(2'h2, XDA, 1'b0, 12'h0, 8'h00, 4'h2);
    err <= 1'b1;
    wr(sfd_pkg::MIRROR_IDX, 32'h0001_0401);
    fr(2'h0, XDA, 1'b0, 12'h0, 8'h00, 4'h6);
    err <= 1'b0;
    wr(sfd_pkg::MIRROR_IDX, 32'h0000_0420);
    fr(2'h2, XDA, 1'b0, 12'h0, 8'h00, 4'h6);
    wr(sfd_pkg::MIRROR_IDX, 32'h0000_0430);
    fr(2'h0, XDA, 1'b0, 12'h0, 8'h00, 4'h6);
    wr(sfd_pkg::GCTRL_IDX, 32'h0000_0001);
    fr(2'h0, XDA, 1'b0, 12'h0, 8'h00, 4'h2);
    wr(sfd_pkg::MIRROR_IDX, 32'h0000_0421);
    fr(2'h0, XDA, 1'b0, 12'h0, 8'h00, 4'h6);
    $display("test mirror done");
    wr(sfd_pkg::GCTRL_IDX, 32'h0000_0080);
    wr(sfd_pkg::MIRROR_IDX, 32'h0000_0000);
    wr(sfd_pkg::PORT_DEFAULT_VLAN_ID_IDX, 32'h0000_0005);
    vl(12'h005, 5'h06);
    vl(12'h007, 5'h07);
    fr(2'h0, UDA, 1'b0, 12'h0, 8'h00, 4'h6);
    fr(2'h0, UDA, 1'b1, 12'h0, 8'h00, 4'h6);
    rd(sfd_pkg::STATUS_IDX, sfd_pkg::RESP_OKAY, st0);
    sa <= BDA;
    fr(2'h2, UDA, 1'b1, 12'h006, 8'h00, 4'h0);
    rd(sfd_pkg::STATUS_IDX, sfd_pkg::RESP_OKAY, d);
    cmp(d[31:16], st0[31:16] + 16'h1);
    cmp(d[15:0], st0[15:0]);
    sa <= ADA;
    fr(2'h1, UDA, 1'b1, 12'h005, 8'h00, 4'h4);
    fr(2'h1, UDA, 1'b1, 12'h005, 8'h00, 4'h4);
    rd(sfd_pkg::STATUS_IDX, sfd_pkg::RESP_OKAY, st0);
    cmp(st0[15:0], d[15:0] + 16'h1);
    sa <= CDA;
    fr(2'h3, UDA, 1'b1, 12'h006, 8'h44, 4'h2);
    fr(2'h0, ADA, 1'b1, 12'h005, 8'h00, 4'h2);
    fr(2'h0, BDA, 1'b1, 12'h005, 8'h00, 4'h6);
    fr(2'h0, XDA, 1'b1, 12'h005, 8'h00, 4'h2);
    fr(2'h0, YDA, 1'b1, 12'h005, 8'h00, 4'h6);
    fr(2'h0, ZDA, 1'b1, 12'h005, 8'h00, 4'h4);
    wr(sfd_pkg::PCTRL2_IDX, 32'h0000_0040);
    fr(2'h0, UDA, 1'b1, 12'h005, 8'h00, 4'h0);
    wr(sfd_pkg::PCTRL2_IDX, 32'h0000_2000);
    fr(2'h1, UDA, 1'b1, 12'h007, 8'h00, 4'h0);
    $display("test vlan done");
    end_sim();
  end
endmodule
